// >>> rtl/sphp_pkg.sv
// package for the stream packet header port: header field positions,
// transaction classes, beat and header carriers, and field helpers.
// assumes a 64-bit stream data path with an 8-bit keep bus.
package sphp_pkg;

  // ----------------------------------------------------------------
  // widths and header field positions
  // ----------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int KEEP_W = 8;
  localparam int USER_W = 32;
  localparam int TID_LO = 56;
  localparam int FTYPE_LO = 52;
  localparam int TTYPE_LO = 48;
  localparam int PRIO_LO = 45;
  localparam int CRF_BIT = 44;
  localparam int SIZE_LO = 36;
  localparam int ERR_BIT = 35;
  localparam int ADDR_LO = 0;
  localparam int INFO_LO = 16;
  localparam int MLEN_LO = 60;
  localparam int MSEG_LO = 56;
  localparam int MBOX_LO = 4;
  localparam int LTR_LO = 0;
  localparam int MAX_BYTES = 256;

  // ----------------------------------------------------------------
  // transaction classes, types and status codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FT_NREAD = 4'h2;
  localparam logic [3:0] FT_WRITE = 4'h5;
  localparam logic [3:0] FT_SWRITE = 4'h6;
  localparam logic [3:0] FT_DBELL = 4'hA;
  localparam logic [3:0] FT_MSG = 4'hB;
  localparam logic [3:0] FT_RESP = 4'hD;
  localparam logic [3:0] TT_RESP_DATA = 4'h8;
  localparam logic [3:0] STATUS_DONE = 4'h0;
  localparam logic [15:0] FT_ALLOWED = 16'h2C64;

  typedef struct packed {
    logic [7:0] tid;
    logic [3:0] ftype;
    logic [3:0] ttype;
    logic [1:0] prio;
    logic crf;
    logic [7:0] size;
    logic err;
    logic [33:0] addr;
    logic [15:0] info;
    logic [3:0] msglen;
    logic [3:0] msgseg;
    logic [5:0] mbox;
    logic [1:0] letter;
    logic [15:0] src;
    logic [15:0] dst;
  } sphp_hdr_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [KEEP_W-1:0] keep;
    logic last;
  } sphp_beat_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // reverse the byte order of one beat
  function automatic logic [DATA_W-1:0] byte_rev(input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < KEEP_W; i++)
    begin
      r[8*i +: 8] = d[8*(KEEP_W-1-i) +: 8];
    end
    return r;
  endfunction

  // beats of payload advertised by a size field
  function automatic logic [5:0] size_beats(input logic [7:0] sz);
    return {1'b0, sz[7:3]} + 6'h01;
  endfunction

  // does this class and type carry payload beats
  function automatic logic has_payload(input logic [3:0] ft,
                                       input logic [3:0] tt);
    return (ft == FT_WRITE) || (ft == FT_SWRITE) || (ft == FT_MSG) ||
           ((ft == FT_RESP) && (tt == TT_RESP_DATA));
  endfunction

endpackage

// >>> rtl/sphp_port.sv
// stream packet header port: user-facing side of the logical layer.
// the transmit path takes user packets and hands them to the core with
// decoded header fields; the receive path builds compact headers for
// packets that the core delivers. assumes all ports on mclk.
module sphp_port
  import sphp_pkg::*;
#(
  parameter logic [15:0] FTYPE_EN = 16'h2C64
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic raw_mode,
  input wire logic s_tvalid,
  output logic s_tready,
  input wire logic [sphp_pkg::DATA_W-1:0] s_tdata,
  input wire logic [sphp_pkg::KEEP_W-1:0] s_tkeep,
  input wire logic s_tlast,
  input wire logic [sphp_pkg::USER_W-1:0] s_tuser,
  output logic m_tvalid,
  input wire logic m_tready,
  output sphp_pkg::sphp_beat_t m_beat,
  output sphp_pkg::sphp_hdr_t tx_hdr,
  output logic tx_bad_ftype,
  output logic tx_overrun,
  input wire logic rx_hvalid,
  output logic rx_hready,
  input wire sphp_pkg::sphp_hdr_t rx_hdr,
  input wire logic [3:0] rx_status,
  input wire logic rx_pvalid,
  output logic rx_pready,
  input wire sphp_pkg::sphp_beat_t rx_pbeat,
  output logic u_tvalid,
  input wire logic u_tready,
  output sphp_pkg::sphp_beat_t u_beat,
  output logic [sphp_pkg::USER_W-1:0] u_tuser
);
  import sphp_pkg::*;

  if ((FTYPE_EN & ~FT_ALLOWED) != 16'h0000)
  begin : g_chk
    $error("FTYPE_EN enables a class the compact format cannot carry");
  end

  // ----------------------------------------------------------------
  // header field helpers
  // ----------------------------------------------------------------
  // class enabled in this build
  function automatic logic ftype_ok(input logic [3:0] ft);
    return FTYPE_EN[ft];
  endfunction

  // decode a header beat, zeroing fields reserved for its class
  function automatic sphp_hdr_t unpack_hdr(input logic [63:0] d,
                                           input logic [31:0] u);
    sphp_hdr_t h;
    logic [3:0] ft;
    h = '0;
    ft = d[FTYPE_LO +: 4];
    h.ftype = ft;
    h.prio = d[PRIO_LO +: 2];
    h.crf = d[CRF_BIT];
    if ((ft != FT_SWRITE) && (ft != FT_MSG))
    begin
      h.tid = d[TID_LO +: 8];
    end
    if ((ft == FT_NREAD) || (ft == FT_WRITE) || (ft == FT_RESP))
    begin
      h.ttype = d[TTYPE_LO +: 4];
    end
    if ((ft == FT_NREAD) || (ft == FT_WRITE) || (ft == FT_MSG))
    begin
      h.size = d[SIZE_LO +: 8];
    end
    if (ft == FT_RESP)
    begin
      h.err = d[ERR_BIT];
    end
    if ((ft == FT_NREAD) || (ft == FT_WRITE) || (ft == FT_SWRITE))
    begin
      h.addr = d[ADDR_LO +: 34];
    end
    if (ft == FT_DBELL)
    begin
      h.info = d[INFO_LO +: 16];
    end
    if (ft == FT_MSG)
    begin
      h.msglen = d[MLEN_LO +: 4];
      h.msgseg = (h.msglen == 4'h0) ? 4'h0 : d[MSEG_LO +: 4];
      h.mbox = (h.msglen == 4'h0) ? d[MBOX_LO +: 6]
                                  : {4'h0, d[MBOX_LO +: 2]};
      h.letter = d[LTR_LO +: 2];
    end
    h.src = u[31:16];
    h.dst = u[15:0];
    return h;
  endfunction

  // build a header beat from fields; unused fields are zero
  function automatic logic [63:0] pack_hdr(input sphp_hdr_t h);
    logic [63:0] d;
    logic [3:0] ft;
    d = '0;
    ft = h.ftype;
    // fields from the core may hold junk where the class reserves them
    if ((ft == FT_NREAD) || (ft == FT_WRITE) || (ft == FT_SWRITE))
    begin
      d[ADDR_LO +: 34] = h.addr;
    end
    if (ft == FT_DBELL)
    begin
      d[INFO_LO +: 16] = h.info;
    end
    if (ft == FT_MSG)
    begin
      d[MBOX_LO +: 6] = (h.msglen == 4'h0) ? h.mbox
                                           : {4'h0, h.mbox[1:0]};
      d[LTR_LO +: 2] = h.letter;
      d[MLEN_LO +: 4] = h.msglen;
      d[MSEG_LO +: 4] = (h.msglen == 4'h0) ? 4'h0 : h.msgseg;
    end
    else if (ft != FT_SWRITE)
    begin
      d[TID_LO +: 8] = h.tid;
    end
    d[FTYPE_LO +: 4] = ft;
    if ((ft == FT_NREAD) || (ft == FT_WRITE) || (ft == FT_RESP))
    begin
      d[TTYPE_LO +: 4] = h.ttype;
    end
    d[PRIO_LO +: 2] = h.prio;
    d[CRF_BIT] = h.crf;
    if ((ft == FT_NREAD) || (ft == FT_WRITE) || (ft == FT_MSG))
    begin
      d[SIZE_LO +: 8] = h.size;
    end
    if (ft == FT_RESP)
    begin
      d[ERR_BIT] = h.err;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // transmit path: user to core
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_PAY, TX_DROP} sphp_tx_t;
  sphp_tx_t tx_state_q;
  logic tx_raw_q;
  logic [5:0] tx_left_q;
  logic m_valid_q;
  sphp_beat_t m_beat_q;
  sphp_hdr_t tx_hdr_q;
  logic bad_q;
  logic over_q;
  logic s_fire;
  logic hdr_fire;
  logic raw_now;
  logic bad_hdr;
  logic fwd;
  sphp_hdr_t hdr_in;

  // accept when the output slot frees; drop state always swallows
  assign s_tready = (tx_state_q == TX_DROP) || !m_valid_q || m_tready;
  assign s_fire = s_tvalid && s_tready;
  assign hdr_fire = s_fire && (tx_state_q == TX_IDLE);
  assign raw_now = (tx_state_q == TX_IDLE) ? raw_mode : tx_raw_q;
  assign hdr_in = unpack_hdr(s_tdata, s_tuser);
  assign bad_hdr = hdr_fire && !raw_mode &&
                   !ftype_ok(s_tdata[FTYPE_LO +: 4]);
  assign fwd = s_fire && !bad_hdr && (tx_state_q != TX_DROP);

  // packet state: last ends the packet whatever the size says
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_q <= TX_IDLE;
    end
    else if (s_fire)
    begin
      if (s_tlast)
      begin
        tx_state_q <= TX_IDLE;
      end
      else if (bad_hdr)
      begin
        tx_state_q <= TX_DROP;
      end
      else if (tx_state_q == TX_IDLE)
      begin
        tx_state_q <= TX_PAY;
      end
    end
  end

  // format and header fields latched on the first beat only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_raw_q <= 1'b0;
      tx_hdr_q <= '0;
      tx_left_q <= 6'h00;
    end
    else if (hdr_fire)
    begin
      tx_raw_q <= raw_mode;
      tx_hdr_q <= raw_mode ? '0 : hdr_in;
      tx_left_q <= has_payload(hdr_in.ftype, hdr_in.ttype) ?
                   size_beats(hdr_in.size) : 6'h00;
    end
    else if (fwd && !tx_raw_q && (tx_left_q != 6'h00))
    begin
      tx_left_q <= tx_left_q - 6'h01;
    end
  end

  // output beat register toward the core
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      m_valid_q <= 1'b0;
      m_beat_q <= '0;
    end
    else if (fwd)
    begin
      m_valid_q <= 1'b1;
      m_beat_q.keep <= s_tkeep;
      m_beat_q.last <= s_tlast;
      if (raw_now)
      begin
        m_beat_q.data <= byte_rev(s_tdata);
      end
      else if (tx_state_q == TX_IDLE)
      begin
        m_beat_q.data <= pack_hdr(hdr_in);
      end
      else
      begin
        m_beat_q.data <= s_tdata;
      end
    end
    else if (m_tready)
    begin
      m_valid_q <= 1'b0;
    end
  end

  // one-cycle event flags
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bad_q <= 1'b0;
      over_q <= 1'b0;
    end
    else
    begin
      bad_q <= bad_hdr;
      over_q <= fwd && !tx_raw_q && (tx_state_q == TX_PAY) &&
                (tx_left_q == 6'h00);
    end
  end

  assign m_tvalid = m_valid_q;
  assign m_beat = m_beat_q;
  assign tx_hdr = tx_hdr_q;
  assign tx_bad_ftype = bad_q;
  assign tx_overrun = over_q;

  // ----------------------------------------------------------------
  // receive path: core to user
  // ----------------------------------------------------------------
  typedef enum logic {RX_HDR, RX_PAY} sphp_rx_t;
  sphp_rx_t rx_state_q;
  logic rx_raw_q;
  logic u_valid_q;
  sphp_beat_t u_beat_q;
  logic [USER_W-1:0] u_user_q;
  logic u_free;
  logic rh_fire;
  logic rp_fire;
  logic rh_pay;
  logic rh_err;

  assign u_free = !u_valid_q || u_tready;
  assign rx_hready = u_free && (rx_state_q == RX_HDR) && !raw_mode;
  assign rx_pready = u_free && ((rx_state_q == RX_PAY) ||
                                raw_mode);
  assign rh_fire = rx_hvalid && rx_hready;
  assign rp_fire = rx_pvalid && rx_pready;
  assign rh_pay = has_payload(rx_hdr.ftype, rx_hdr.ttype);
  assign rh_err = (rx_hdr.ftype == FT_RESP) &&
                  (rx_status != STATUS_DONE);

  // header state, then payload until last
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_q <= RX_HDR;
      rx_raw_q <= 1'b0;
    end
    else if (rh_fire && rh_pay)
    begin
      rx_state_q <= RX_PAY;
      rx_raw_q <= 1'b0;
    end
    else if (rp_fire && (rx_state_q == RX_HDR))
    begin
      rx_state_q <= rx_pbeat.last ? RX_HDR : RX_PAY;
      rx_raw_q <= 1'b1;
    end
    else if (rp_fire && rx_pbeat.last)
    begin
      rx_state_q <= RX_HDR;
    end
  end

  // output beat register toward the user
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      u_valid_q <= 1'b0;
      u_beat_q <= '0;
      u_user_q <= '0;
    end
    else if (rh_fire)
    begin
      u_valid_q <= 1'b1;
      u_beat_q.data <= pack_hdr('{tid: rx_hdr.tid, ftype: rx_hdr.ftype,
        ttype: rx_hdr.ttype, prio: rx_hdr.prio, crf: rx_hdr.crf,
        size: rx_hdr.size, err: rh_err, addr: rx_hdr.addr,
        info: rx_hdr.info, msglen: rx_hdr.msglen, msgseg: rx_hdr.msgseg,
        mbox: rx_hdr.mbox, letter: rx_hdr.letter, src: rx_hdr.src,
        dst: rx_hdr.dst});
      u_beat_q.keep <= {KEEP_W{1'b1}};
      u_beat_q.last <= !rh_pay;
      u_user_q <= {rx_hdr.src, rx_hdr.dst};
    end
    else if (rp_fire)
    begin
      u_valid_q <= 1'b1;
      u_beat_q.data <= (raw_mode && (rx_state_q == RX_HDR)) || rx_raw_q ?
                       byte_rev(rx_pbeat.data) : rx_pbeat.data;
      u_beat_q.keep <= rx_pbeat.keep;
      u_beat_q.last <= rx_pbeat.last;
    end
    else if (u_tready)
    begin
      u_valid_q <= 1'b0;
    end
  end

  assign u_tvalid = u_valid_q;
  assign u_beat = u_beat_q;
  assign u_tuser = u_user_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence seq_good_hdr;
    hdr_fire && !raw_mode && !bad_hdr && (hdr_in.ftype != FT_MSG);
  endsequence

  a_tx_hold_stall: assert property (m_tvalid && !m_tready |=>
    m_tvalid && $stable(m_beat)) else $error("tx beat changed in stall");
  a_rx_hold_stall: assert property (u_tvalid && !u_tready |=>
    u_tvalid && $stable(u_beat)) else $error("rx beat changed in stall");
  a_tid_capture: assert property (seq_good_hdr |=>
    m_beat.data[TID_LO +: 8] == tx_hdr.tid)
    else $error("header id mismatch");
  a_bad_class_drop: assert property (bad_hdr && !s_tlast |=>
    tx_bad_ftype ##1 (s_tready && !(m_tvalid && m_tready && m_beat.last)))
    else $error("bad class not dropped");
  a_ids_first_beat: assert property ((tx_state_q == TX_PAY) |=>
    $stable(tx_hdr.src) && $stable(tx_hdr.dst))
    else $error("ids changed after first beat");
  a_resp_err_bit: assert property (rh_fire ##1 1'b1 |->
    u_beat.data[ERR_BIT] == $past(rh_err))
    else $error("response error bit wrong");
  a_rx_hdr_first: assert property (rh_fire |=> u_tvalid &&
    u_beat.data[FTYPE_LO +: 4] == $past(rx_hdr.ftype))
    else $error("header not on first beat");
  a_raw_reverse: assert property (fwd && raw_now |=>
    m_beat.data == byte_rev($past(s_tdata)))
    else $error("raw beat not reversed");
  a_short_last: assert property (fwd && s_tlast |=>
    m_tvalid && m_beat.last && (tx_state_q == TX_IDLE))
    else $error("short payload not ended");
  a_resv_zero: assert property (rh_fire && rx_hdr.ftype == FT_RESP
    |=> u_beat.data[33:0] == 34'h0) else $error("reserved field not zero");
endmodule

// >>> bench/sphp_user_model.sv
// user-side model of the stream packet header port: a stream master
// that presents packets beat by beat and a stream sink for received ones.
// assumes sphp_pkg is compiled first and one clock, mclk.
module sphp_user_model
  import sphp_pkg::*;
(
  input wire logic mclk,
  input wire logic slow,
  output logic s_tvalid,
  input wire logic s_tready,
  output logic [sphp_pkg::DATA_W-1:0] s_tdata,
  output logic [sphp_pkg::KEEP_W-1:0] s_tkeep,
  output logic s_tlast,
  output logic [sphp_pkg::USER_W-1:0] s_tuser,
  input wire logic u_tvalid,
  output logic u_tready,
  input wire sphp_pkg::sphp_beat_t u_beat,
  input wire logic [sphp_pkg::USER_W-1:0] u_tuser
);
  timeunit 1ns;
  timeprecision 1ps;
  sphp_beat_t got[$];
  logic [31:0] got_user[$];
  int to = 0;

  // ------------------------------------------------------------
  // sink and source
  // ------------------------------------------------------------
  // idle values at time zero; keep is all ones throughout
  initial
  begin
    s_tvalid = 1'b0;
    s_tdata = '0;
    s_tkeep = '1;
    s_tlast = 1'b0;
    s_tuser = '0;
    u_tready = 1'b1;
  end

  // sink takes on valid and ready; stalls every other cycle when slow
  always @(posedge mclk)
  begin
    if (u_tvalid && u_tready)
    begin
      got.push_back(u_beat);
      got_user.push_back(u_tuser);
    end
    u_tready <= slow ? ~u_tready : 1'b1;
  end

  // one beat, held until taken; callers keep priority 0..2, aligned
  // addresses, legal sizes and at most 256 bytes
  task automatic put(input logic [63:0] d, input logic l,
                     input logic [31:0] u);
    int i;
    s_tvalid <= 1'b1;
    s_tdata <= d;
    s_tlast <= l;
    s_tuser <= u;
    for (i = 0; i < 50; i++)
    begin
      @(negedge mclk);
      if (s_tready === 1'b1)
        break;
    end
    if (i == 50)
      to++;
    @(posedge mclk);
  endtask

  // released lines show the inverse of their last value
  task automatic pause();
    s_tvalid <= 1'b0;
    s_tlast <= 1'b0;
    s_tdata <= ~s_tdata;
    s_tuser <= ~s_tuser;
    @(posedge mclk);
  endtask
endmodule

// >>> bench/stream_packet_header_port_tb.sv
// self-checking bench for the stream packet header port
// assumes sphp_pkg and sphp_user_model are compiled first
module stream_packet_header_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sphp_pkg::*;

  // ------------------------------------------------------------
  // clock, reset and wiring
  // ------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic raw_mode = 1'b0;
  logic slow = 1'b0;
  logic mslow = 1'b0;
  logic m_tready = 1'b1;
  logic rx_hvalid = 1'b0;
  logic rx_pvalid = 1'b0;
  logic [3:0] rx_status = 4'h0;
  sphp_hdr_t rx_hdr = '0;
  sphp_beat_t rx_pbeat = '0;
  logic s_tvalid, s_tready, s_tlast, m_tvalid, u_tvalid, u_tready;
  logic tx_bad_ftype, tx_overrun, rx_hready, rx_pready;
  logic [63:0] s_tdata;
  logic [7:0] s_tkeep;
  logic [31:0] s_tuser, u_tuser;
  sphp_beat_t m_beat, u_beat;
  sphp_hdr_t tx_hdr;
  sphp_beat_t mq[$];
  int errors = 0;
  int n_tests = 0;
  int nbad = 0;
  int nov = 0;

  always #20 mclk = ~mclk;

  sphp_port u_dut (.mclk(mclk), .rst_n(rst_n), .raw_mode(raw_mode),
    .s_tvalid(s_tvalid), .s_tready(s_tready), .s_tdata(s_tdata),
    .s_tkeep(s_tkeep), .s_tlast(s_tlast), .s_tuser(s_tuser),
    .m_tvalid(m_tvalid), .m_tready(m_tready), .m_beat(m_beat),
    .tx_hdr(tx_hdr), .tx_bad_ftype(tx_bad_ftype), .tx_overrun(tx_overrun),
    .rx_hvalid(rx_hvalid), .rx_hready(rx_hready), .rx_hdr(rx_hdr),
    .rx_status(rx_status), .rx_pvalid(rx_pvalid), .rx_pready(rx_pready),
    .rx_pbeat(rx_pbeat), .u_tvalid(u_tvalid), .u_tready(u_tready),
    .u_beat(u_beat), .u_tuser(u_tuser));

  sphp_user_model u_usr (.mclk(mclk), .slow(slow), .s_tvalid(s_tvalid),
    .s_tready(s_tready), .s_tdata(s_tdata), .s_tkeep(s_tkeep),
    .s_tlast(s_tlast), .s_tuser(s_tuser), .u_tvalid(u_tvalid),
    .u_tready(u_tready), .u_beat(u_beat), .u_tuser(u_tuser));

  // core-side sink and pulse counters; stalls every other cycle when mslow
  always @(posedge mclk)
  begin
    if (m_tvalid && m_tready)
      mq.push_back(m_beat);
    if (tx_bad_ftype)
      nbad++;
    if (tx_overrun)
      nov++;
    m_tready <= mslow ? ~m_tready : 1'b1;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    errors = errors + u_usr.to;
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // compact header word with reserved bits 47, 35 and 34 at zero
  function automatic logic [63:0] hw(input logic [7:0] tid,
    input logic [3:0] ft, input logic [3:0] tt, input logic [1:0] pr,
    input logic crf, input logic [7:0] sz, input logic [33:0] a);
    return {tid, ft, tt, 1'b0, pr, crf, sz, 2'b00, a};
  endfunction

  // waits for nm core beats and nu user beats, bounded
  task automatic settle(input int nm, input int nu);
    int i;
    for (i = 0; i < 200; i++)
    begin
      @(posedge mclk);
      if (mq.size() >= nm && u_usr.got.size() >= nu)
        break;
    end
    if (i == 200)
    begin
      errors++;
      finish_test();
    end
    repeat (2) @(posedge mclk);
  endtask

  task automatic clr();
    mq.delete();
    u_usr.got.delete();
    u_usr.got_user.delete();
    nbad = 0;
    nov = 0;
  endtask

  task automatic rx_head(input sphp_hdr_t h, input logic [3:0] st);
    int i;
    rx_hvalid <= 1'b1;
    rx_hdr <= h;
    rx_status <= st;
    for (i = 0; i < 50; i++)
    begin
      @(negedge mclk);
      if (rx_hready === 1'b1)
        break;
    end
    if (i == 50)
    begin
      errors++;
      finish_test();
    end
    @(posedge mclk);
    rx_hvalid <= 1'b0;
    rx_hdr <= ~h;
    @(posedge mclk);
  endtask

  task automatic rx_pay(input logic [63:0] d);
    int i;
    rx_pvalid <= 1'b1;
    rx_pbeat <= '{data: d, keep: 8'hFF, last: 1'b1};
    for (i = 0; i < 50; i++)
    begin
      @(negedge mclk);
      if (rx_pready === 1'b1)
        break;
    end
    if (i == 50)
    begin
      errors++;
      finish_test();
    end
    @(posedge mclk);
    rx_pvalid <= 1'b0;
    rx_pbeat <= '{data: ~d, keep: 8'h00, last: 1'b0};
    @(posedge mclk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // write with stalls; reserved header bits set on input; user changes
  task automatic t_tx_write();
    logic [63:0] h;
    h = hw(8'h5A, FT_WRITE, 4'h4, 2'h1, 1'b1, 8'h0F, 34'h2_1234_5670);
    clr();
    mslow <= 1'b1;
    u_usr.put(h | 64'h0000_800C_0000_0000, 1'b0, 32'hAAAA_5555);
    u_usr.put(64'h1111_2222_3333_4444, 1'b0, 32'hDEAD_BEEF);
    u_usr.put(64'h5555_6666_7777_8888, 1'b1, 32'h0000_0000);
    u_usr.pause();
    settle(3, 0);
    mslow <= 1'b0;
    check(mq[0].data, h);
    check({mq[0].last, mq[0].keep}, 9'h0FF);
    check(mq[1].data, 64'h1111_2222_3333_4444);
    check({mq[1].last, mq[2].last}, 2'b01);
    check({tx_hdr.tid, tx_hdr.ftype, tx_hdr.ttype}, 16'h5A54);
    check({tx_hdr.prio, tx_hdr.crf, tx_hdr.size}, 11'h30F);
    check(tx_hdr.addr, 34'h2_1234_5670);
    check({tx_hdr.src, tx_hdr.dst}, 32'hAAAA_5555);
    check(nov, 0);
  endtask

  // two header-only reads back to back, then a one-beat write overrun
  task automatic t_tx_b2b();
    clr();
    u_usr.put(hw(8'h01, FT_NREAD, 4'h4, 2'h0, 1'b0, 8'h07, 34'h8), 1'b1, 0);
    u_usr.put(hw(8'h02, FT_NREAD, 4'h4, 2'h2, 1'b0, 8'hFF, 34'h0), 1'b1, 0);
    u_usr.put(hw(8'h03, FT_WRITE, 4'h4, 2'h0, 1'b0, 8'h07, 34'h0), 1'b0, 0);
    u_usr.put(64'hA5, 1'b0, 0);
    u_usr.put(64'h5A, 1'b1, 0);
    u_usr.pause();
    settle(5, 0);
    check({mq[0].last, mq[1].last, mq[2].last}, 3'b110);
    check(mq[1].data[43:36], 8'hFF);
    check(nov, 1);
    check(mq[4].data, 64'h5A);
  endtask

  // short write ends at last marker; a doorbell follows
  task automatic t_tx_short();
    logic [63:0] d;
    d = hw(8'h33, FT_DBELL, 4'h3, 2'h1, 1'b0, 8'h00, {2'b0, 32'hBEEF_0000});
    clr();
    u_usr.put(hw(8'h09, FT_WRITE, 4'h5, 2'h1, 1'b0, 8'h1F, 34'h100), 1'b0, 0);
    u_usr.put(64'h0123_4567_89AB_CDEF, 1'b1, 0);
    u_usr.put(d, 1'b1, 32'h0001_0002);
    u_usr.pause();
    settle(3, 0);
    check({mq[1].last, mq[2].last}, 2'b11);
    check(mq[2].data[31:16], 16'hBEEF);
    check(mq[2].data[51:48], 4'h0);
    check({tx_hdr.ftype, tx_hdr.info}, 20'hA_BEEF);
    check(tx_hdr.size, 8'h00);
    check(nov, 0);
  endtask

  // class 8 is refused: header and payload swallowed, one pulse
  task automatic t_tx_refuse();
    clr();
    u_usr.put(hw(8'h04, 4'h8, 4'h1, 2'h0, 1'b0, 8'h07, 34'h0), 1'b0, 0);
    u_usr.put(64'h77, 1'b1, 0);
    u_usr.pause();
    settle(0, 0);
    check(mq.size(), 0);
    check(nbad, 1);
  endtask

  // raw format: every beat byte-reversed in both directions
  task automatic t_raw();
    clr();
    raw_mode <= 1'b1;
    u_usr.put(64'h0102_0304_0506_0708, 1'b1, 0);
    u_usr.pause();
    rx_pay(64'h1122_3344_5566_7788);
    settle(1, 1);
    raw_mode <= 1'b0;
    check(mq[0].data, 64'h0807_0605_0403_0201);
    check(u_usr.got[0].data, 64'h8877_6655_4433_2211);
  endtask

  // response status folds to one bit
  task automatic t_rx_status();
    sphp_hdr_t h;
    logic [63:0] e;
    logic [3:0] st[3] = '{4'h0, 4'h3, 4'h7};
    for (int i = 0; i < 3; i++)
    begin
      clr();
      h = '0;
      h.tid = 8'h40 + 8'(i);
      h.ftype = FT_RESP;
      h.prio = 2'h2;
      h.crf = 1'b1;
      h.addr = 34'h1_2345_6788;
      h.size = 8'h3F;
      h.src = 16'h00A1;
      h.dst = 16'h00B2;
      rx_head(h, st[i]);
      settle(0, 1);
      e = hw(h.tid, FT_RESP, 4'h0, 2'h2, 1'b1, 8'h00, 34'h0);
      e[35] = (st[i] != STATUS_DONE);
      check(u_usr.got[0].data, e);
      check({u_usr.got[0].last, u_usr.got[0].keep}, 9'h1FF);
      check(u_usr.got_user[0], 32'h00A1_00B2);
    end
  endtask

  // single- and multi-segment messages with payload, slow user sink
  task automatic t_rx_msg();
    sphp_hdr_t h;
    logic [63:0] e;
    slow <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      clr();
      h = '0;
      h.ftype = FT_MSG;
      h.size = 8'h07;
      h.msglen = (i == 0) ? 4'h0 : 4'h3;
      h.msgseg = 4'h1;
      h.mbox = 6'h2A;
      h.letter = 2'h2;
      rx_head(h, 4'h0);
      rx_pay(64'hCAFE_F00D_0000_0001);
      settle(0, 2);
      e = {h.msglen, (i == 0) ? 4'h0 : 4'h1, FT_MSG, 4'h0, 4'h0, 8'h07,
           26'h0, (i == 0) ? 6'h2A : 6'h02, 4'h2};
      check(u_usr.got[0].data, e);
      check(u_usr.got[1].data, 64'hCAFE_F00D_0000_0001);
      check(u_usr.got[1].last, 1'b1);
    end
    slow <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_tx_write();
    t_tx_b2b();
    t_tx_short();
    t_tx_refuse();
    t_raw();
    t_rx_status();
    t_rx_msg();
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    finish_test();
  end
endmodule
